// file: src/tpc_defs.svh
// Offsets, field positions, reset values and timing counts of the port control
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define TPC_REG_NET      8'h00
`define TPC_REG_PORT_EN  8'h04
`define TPC_REG_LINK_EN  8'h08
`define TPC_REG_SQ_LOW   8'h0C
`define TPC_REG_XOVER    8'h10
`define TPC_REG_OVR      8'h14
`define TPC_REG_STAT     8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TPC_OVR_NET_BIT  0
`define TPC_OVR_EN_BIT   1
`define TPC_OVR_LI_BIT   2
`define TPC_OVR_SQ_BIT   3
`define TPC_OVR_XO_BIT   4
`define TPC_STAT_JAB_LSB 8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TPC_RST_PORTS    8'h00
`define TPC_RST_OVR      5'h00
`define TPC_RST_DATA     32'h0000_0000

// ----------------------------------------------------------------------------
// Timing: clock rate, blink slot and activity sampling window
// ----------------------------------------------------------------------------
`define TPC_CLK_MHZ      200
`define TPC_BLINK_MS     100
`define TPC_ACT_WIN_MS   50
`define TPC_BLINK_CYC    (`TPC_BLINK_MS * 1000 * `TPC_CLK_MHZ)
`define TPC_ACT_WIN_CYC  (`TPC_ACT_WIN_MS * 1000 * `TPC_CLK_MHZ)

`endif

// file: src/tpc_pkg.sv
// Types shared by the twisted-pair port control block
package tpc_pkg;

   typedef enum logic [1:0]
   {
      TPC_NET_ISO = 2'b00,
      TPC_NET_1   = 2'b01,
      TPC_NET_2   = 2'b10,
      TPC_NET_3   = 2'b11
   } tpc_net_t;

   typedef enum logic [1:0]
   {
      TPC_ACT_OFF   = 2'b00,
      TPC_ACT_ON    = 2'b01,
      TPC_ACT_BLINK = 2'b10
   } tpc_act_mode_t;

   typedef enum logic [2:0]
   {
      TPC_ST_OFF    = 3'b000,
      TPC_ST_ON     = 3'b001,
      TPC_ST_ONE    = 3'b010,
      TPC_ST_TWO    = 3'b011,
      TPC_ST_TIMED  = 3'b100
   } tpc_stat_mode_t;

   typedef struct packed
   {
      tpc_net_t   net;
      logic [7:0] port_en;
      logic [7:0] link_en;
      logic [7:0] sq_low;
      logic       xover;
   } tpc_cfg_t;

   typedef struct packed
   {
      logic [7:0] link_ok;
      logic [7:0] jabber;
      logic [7:0] partition;
      logic [7:0] carrier;
   } tpc_line_t;

endpackage

// file: src/tpc_port_ctrl.sv
// Configuration, backplane selection and LED drive of an 8-port TP module
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "tpc_defs.svh"

module tpc_port_ctrl
#(
   parameter int unsigned BLINK_CYC = `TPC_BLINK_CYC,
   parameter int unsigned ACT_CYC   = `TPC_ACT_WIN_CYC
)
(
   input  wire logic              clk,        // 200 MHz clock
   input  wire logic              rstn,       // Async reset, active low
   input  wire logic              ce,         // Clock enable, freezes all
   input  wire logic [7:0]        addr,       // Register byte address
   input  wire logic [31:0]       wdata,      // Register write data
   input  wire logic              wr,         // Write strobe
   input  wire logic              rd,         // Read strobe
   output logic      [31:0]       rdata,      // Read data, cycle after rd
   input  wire tpc_pkg::tpc_cfg_t sw_cfg,     // On-board switch settings
   input  wire tpc_pkg::tpc_line_t line,      // Per-port line conditions
   output tpc_pkg::tpc_cfg_t      cfg,        // Settings in force
   output logic      [2:0]        bp_conn,    // Backplane net 1..3 connect
   output logic      [7:0]        crossed,    // Port crossover in force
   output logic      [7:0]        led_status, // Green status LEDs
   output logic      [7:0]        led_act     // Yellow activity LEDs
);

   // -------------------------------------------------------------------------
   // Management override store
   // -------------------------------------------------------------------------
   tpc_pkg::tpc_cfg_t mgmt;
   logic [4:0]        ovr;
   tpc_pkg::tpc_cfg_t next_cfg;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mgmt <= '0;
         ovr  <= `TPC_RST_OVR;
      end
      else if (ce && wr)
      begin
         case (addr)
            `TPC_REG_NET:
            begin
               mgmt.net                 <= tpc_pkg::tpc_net_t'(wdata[1:0]);
               ovr[`TPC_OVR_NET_BIT]    <= 1'b1;
            end
            `TPC_REG_PORT_EN:
            begin
               mgmt.port_en             <= wdata[7:0];
               ovr[`TPC_OVR_EN_BIT]     <= 1'b1;
            end
            `TPC_REG_LINK_EN:
            begin
               mgmt.link_en             <= wdata[7:0];
               ovr[`TPC_OVR_LI_BIT]     <= 1'b1;
            end
            `TPC_REG_SQ_LOW:
            begin
               mgmt.sq_low              <= wdata[7:0];
               ovr[`TPC_OVR_SQ_BIT]     <= 1'b1;
            end
            `TPC_REG_XOVER:
            begin
               mgmt.xover               <= wdata[0];
               ovr[`TPC_OVR_XO_BIT]     <= 1'b1;
            end
            // Writing ones hands a setting back to the switches
            `TPC_REG_OVR:
               ovr <= ovr & ~wdata[4:0];
            default:
               ovr <= ovr;
         endcase
      end
   end

   // Management value wins wherever it has been written
   always_comb
   begin
      next_cfg.net     = ovr[`TPC_OVR_NET_BIT] ? mgmt.net     : sw_cfg.net;
      next_cfg.port_en = ovr[`TPC_OVR_EN_BIT]  ? mgmt.port_en : sw_cfg.port_en;
      next_cfg.link_en = ovr[`TPC_OVR_LI_BIT]  ? mgmt.link_en : sw_cfg.link_en;
      next_cfg.sq_low  = ovr[`TPC_OVR_SQ_BIT]  ? mgmt.sq_low  : sw_cfg.sq_low;
      next_cfg.xover   = ovr[`TPC_OVR_XO_BIT]  ? mgmt.xover   : sw_cfg.xover;
   end

   // -------------------------------------------------------------------------
   // Settings in force, backplane and crossover
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cfg     <= '0;
         bp_conn <= 3'h0;
         crossed <= 8'hFF;
      end
      else if (ce)
      begin
         cfg <= next_cfg;
         // One choice for the whole module; isolated keeps all off
         case (next_cfg.net)
            tpc_pkg::TPC_NET_1: bp_conn <= 3'b001;
            tpc_pkg::TPC_NET_2: bp_conn <= 3'b010;
            tpc_pkg::TPC_NET_3: bp_conn <= 3'b100;
            default:            bp_conn <= 3'b000;
         endcase
         crossed <= {~next_cfg.xover, 7'h7F};
      end
   end

   // -------------------------------------------------------------------------
   // Link integrity, jabber and partition error detection
   // -------------------------------------------------------------------------
   // With checking on, missing pulses are an error. With checking off, pulses
   // arriving mean the far end still checks, so the two ends disagree.
   logic [7:0] lnk_err;
   logic [7:0] jab_err;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         lnk_err <= `TPC_RST_PORTS;
         jab_err <= `TPC_RST_PORTS;
      end
      else if (ce)
      begin
         lnk_err <= next_cfg.port_en &
                    ((next_cfg.link_en & ~line.link_ok) |
                     (~next_cfg.link_en & line.link_ok));
         jab_err <= next_cfg.port_en & (line.jabber | line.partition);
      end
   end

   // -------------------------------------------------------------------------
   // Blink timebase
   // -------------------------------------------------------------------------
   logic [31:0] blink_cnt;
   logic        blink_tick;
   logic [2:0]  slot;
   logic [31:0] win_cnt;
   logic        win_end;

   assign blink_tick = (blink_cnt == BLINK_CYC - 1);
   assign win_end    = (win_cnt == ACT_CYC - 1);

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         blink_cnt <= 32'h0000_0000;
         slot      <= 3'h0;
      end
      else if (ce)
      begin
         blink_cnt <= blink_tick ? 32'h0000_0000 : blink_cnt + 32'h0000_0001;
         if (blink_tick)
            slot <= slot + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         win_cnt <= 32'h0000_0000;
      else if (ce)
         win_cnt <= win_end ? 32'h0000_0000 : win_cnt + 32'h0000_0001;
   end

   // -------------------------------------------------------------------------
   // Per-port LED logic
   // -------------------------------------------------------------------------
   // Activity is judged over a whole window, so a short gap between frames
   // reads as blinking rather than flicker at the frame rate.
   tpc_pkg::tpc_act_mode_t  act_mode [8];
   tpc_pkg::tpc_stat_mode_t stat_mode [8];
   logic [7:0]              seen_busy;
   logic [7:0]              seen_idle;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_port
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
            begin
               seen_busy[gi] <= 1'b0;
               seen_idle[gi] <= 1'b0;
               act_mode[gi]  <= tpc_pkg::TPC_ACT_OFF;
            end
            else if (ce)
            begin
               if (win_end)
               begin
                  seen_busy[gi] <= 1'b0;
                  seen_idle[gi] <= 1'b0;
                  if (!seen_busy[gi])
                     act_mode[gi] <= tpc_pkg::TPC_ACT_OFF;
                  else if (!seen_idle[gi])
                     act_mode[gi] <= tpc_pkg::TPC_ACT_ON;
                  else
                     act_mode[gi] <= tpc_pkg::TPC_ACT_BLINK;
               end
               else
               begin
                  seen_busy[gi] <= seen_busy[gi] | line.carrier[gi];
                  seen_idle[gi] <= seen_idle[gi] | ~line.carrier[gi];
               end
            end
         end

         // Errors outrank the timed pattern; disabled outranks all
         always_comb
         begin
            if (!next_cfg.port_en[gi])
               stat_mode[gi] = tpc_pkg::TPC_ST_OFF;
            else if (jab_err[gi])
               stat_mode[gi] = tpc_pkg::TPC_ST_TWO;
            else if (lnk_err[gi])
               stat_mode[gi] = tpc_pkg::TPC_ST_ONE;
            else if (!next_cfg.link_en[gi])
               stat_mode[gi] = tpc_pkg::TPC_ST_TIMED;
            else
               stat_mode[gi] = tpc_pkg::TPC_ST_ON;
         end

         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
            begin
               led_status[gi] <= 1'b0;
               led_act[gi]    <= 1'b0;
            end
            else if (ce)
            begin
               case (stat_mode[gi])
                  tpc_pkg::TPC_ST_ON:    led_status[gi] <= 1'b1;
                  tpc_pkg::TPC_ST_ONE:   led_status[gi] <= (slot == 3'h0);
                  tpc_pkg::TPC_ST_TWO:   led_status[gi] <= (slot == 3'h0) ||
                                                           (slot == 3'h2);
                  tpc_pkg::TPC_ST_TIMED: led_status[gi] <= ~slot[2];
                  default:               led_status[gi] <= 1'b0;
               endcase
               case (act_mode[gi])
                  tpc_pkg::TPC_ACT_ON:    led_act[gi] <= 1'b1;
                  tpc_pkg::TPC_ACT_BLINK: led_act[gi] <= slot[0];
                  default:                led_act[gi] <= 1'b0;
               endcase
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Register read port
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rdata <= `TPC_RST_DATA;
      else if (ce)
      begin
         if (rd)
         begin
            case (addr)
               `TPC_REG_NET:     rdata <= {30'h0, cfg.net};
               `TPC_REG_PORT_EN: rdata <= {24'h0, cfg.port_en};
               `TPC_REG_LINK_EN: rdata <= {24'h0, cfg.link_en};
               `TPC_REG_SQ_LOW:  rdata <= {24'h0, cfg.sq_low};
               `TPC_REG_XOVER:   rdata <= {31'h0, cfg.xover};
               `TPC_REG_OVR:     rdata <= {27'h0, ovr};
               `TPC_REG_STAT:    rdata <= {16'h0, jab_err, lnk_err};
               default:          rdata <= `TPC_RST_DATA;
            endcase
         end
         else
            rdata <= `TPC_RST_DATA;
      end
   end

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   property p_iso_off;
      @(posedge clk) disable iff (!rstn)
      ce && next_cfg.net == tpc_pkg::TPC_NET_ISO |=> bp_conn == 3'b000;
   endproperty
   a_iso_off: assert property (p_iso_off)
      else $error("backplane connected in isolated mode");

   property p_one_net;
      @(posedge clk) disable iff (!rstn)
      ce && next_cfg.net != tpc_pkg::TPC_NET_ISO
      |=> $onehot(bp_conn) && bp_conn[cfg.net - 2'd1];
   endproperty
   a_one_net: assert property (p_one_net)
      else $error("backplane connect does not match network");

   property p_en_write;
      @(posedge clk) disable iff (!rstn)
      ce && wr && addr == `TPC_REG_PORT_EN ##1 ce
      |=> cfg.port_en == $past(wdata[7:0], 2);
   endproperty
   a_en_write: assert property (p_en_write)
      else $error("port enable write not in force");

   property p_xover;
      @(posedge clk) disable iff (!rstn)
      ce |=> crossed[6:0] == 7'h7F && crossed[7] == !$past(next_cfg.xover);
   endproperty
   a_xover: assert property (p_xover)
      else $error("crossover wrong");

   property p_led_dis;
      @(posedge clk) disable iff (!rstn)
      ce && !next_cfg.port_en[0] |=> !led_status[0];
   endproperty
   a_led_dis: assert property (p_led_dis)
      else $error("status LED lit on disabled port");

   property p_li_err;
      @(posedge clk) disable iff (!rstn)
      ce && next_cfg.port_en[0] && next_cfg.link_en[0] && !line.link_ok[0]
      |=> lnk_err[0];
   endproperty
   a_li_err: assert property (p_li_err)
      else $error("link integrity error not flagged");

   property p_li_off;
      @(posedge clk) disable iff (!rstn)
      ce && !next_cfg.link_en[0] && !line.link_ok[0] |=> !lnk_err[0];
   endproperty
   a_li_off: assert property (p_li_off)
      else $error("link check not suppressed");

   property p_ovr_hold;
      @(posedge clk) disable iff (!rstn)
      ovr[`TPC_OVR_SQ_BIT] && !(ce && wr && addr == `TPC_REG_OVR)
      |=> ovr[`TPC_OVR_SQ_BIT];
   endproperty
   a_ovr_hold: assert property (p_ovr_hold)
      else $error("override released without command");

   property p_sw_follow;
      @(posedge clk) disable iff (!rstn)
      ce && !ovr[`TPC_OVR_SQ_BIT] |=> cfg.sq_low == $past(sw_cfg.sq_low);
   endproperty
   a_sw_follow: assert property (p_sw_follow)
      else $error("squelch does not follow switches");

   property p_act_off;
      @(posedge clk) disable iff (!rstn)
      ce && act_mode[0] == tpc_pkg::TPC_ACT_OFF |=> !led_act[0];
   endproperty
   a_act_off: assert property (p_act_off)
      else $error("activity LED lit while idle");

   c_iso:   cover property (@(posedge clk) disable iff (!rstn)
                            cfg.net == tpc_pkg::TPC_NET_ISO ##1
                            cfg.net == tpc_pkg::TPC_NET_2);
   c_ovr:   cover property (@(posedge clk) disable iff (!rstn)
                            $rose(ovr[`TPC_OVR_EN_BIT]));
   c_two:   cover property (@(posedge clk) disable iff (!rstn)
                            stat_mode[0] == tpc_pkg::TPC_ST_TWO &&
                            led_status[0]);
   c_blink: cover property (@(posedge clk) disable iff (!rstn)
                            act_mode[0] == tpc_pkg::TPC_ACT_BLINK);

endmodule

// file: tb/testbench.sv
// Self-checking bench of the twisted-pair port control block
`timescale 1ns/1ps
`include "tpc_defs.svh"

module testbench;

   logic               clk;
   logic               rstn;
   logic               ce;
   logic [7:0]         addr;
   logic [31:0]        wdata;
   logic               wr;
   logic               rd;
   logic [31:0]        rdata;
   tpc_pkg::tpc_cfg_t  sw_cfg;
   tpc_pkg::tpc_line_t line;
   tpc_pkg::tpc_cfg_t  cfg;
   logic [2:0]         bp_conn;
   logic [7:0]         crossed;
   logic [7:0]         led_status;
   logic [7:0]         led_act;
   logic [7:0]         peer_li;
   logic [7:0]         peer_cross;
   logic [7:0]         jab;
   logic [7:0]         part;
   logic [7:0]         busy;
   logic [7:0]         pkt;
   int                 fail_count;
   int                 total_checks;

   tpc_port_ctrl #(.BLINK_CYC(8), .ACT_CYC(16)) dut
   (
      .clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .sw_cfg(sw_cfg), .line(line),
      .cfg(cfg), .bp_conn(bp_conn), .crossed(crossed),
      .led_status(led_status), .led_act(led_act)
   );

   tpc_link_partner partner
   (
      .clk(clk), .rstn(rstn), .crossed(crossed), .hub_sq(cfg.sq_low),
      .peer_li(peer_li), .peer_cross(peer_cross), .jab(jab), .part(part),
      .busy(busy), .pkt(pkt), .line(line)
   );

   always #2.5 clk = ~clk;

   // ---------------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------------
   task automatic check_val(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      check_val($sformatf("read %h", a), exp, rdata);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Any 64-cycle span holds exactly one full 8-slot pattern
   task automatic count_led(input bit act, input int idx, input int exp);
      int n;
      n = 0;
      repeat (64)
      begin
         @(posedge clk);
         #1;
         n += act ? (led_act[idx] === 1'b1) : (led_status[idx] === 1'b1);
      end
      check_val($sformatf("led %0d/%0d lit cycles", act, idx), exp, n);
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ---------------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------------
   task automatic t_reset;
      wait_cyc(3);
      check_val("cfg", {5'h0, sw_cfg}, {5'h0, cfg});
      check_val("crossed", 32'h0000_00FF, {24'h0, crossed});
      check_val("bp_conn", 32'h0000_0002, {29'h0, bp_conn});
      rd_chk(`TPC_REG_OVR, 32'h0000_0000);
      rd_chk(8'h40, 32'h0000_0000);
      $display("t_reset done");
   endtask

   task automatic t_net;
      logic [2:0] exp_bp [4];
      exp_bp = '{3'b000, 3'b001, 3'b010, 3'b100};
      for (int n = 0; n < 4; n++)
      begin
         bus_write(`TPC_REG_NET, 32'(n));
         wait_cyc(3);
         check_val("bp_conn", {29'h0, exp_bp[n]}, {29'h0, bp_conn});
         rd_chk(`TPC_REG_NET, 32'(n));
      end
      sw_cfg.net <= tpc_pkg::TPC_NET_1;
      wait_cyc(3);
      check_val("held net", 32'h0000_0003, {30'h0, cfg.net});
      bus_write(`TPC_REG_OVR, 32'h0000_0001);
      wait_cyc(3);
      check_val("switch net", 32'h0000_0001, {29'h0, bp_conn});
      $display("t_net done");
   endtask

   task automatic t_ports;
      bus_write(`TPC_REG_PORT_EN, 32'h0000_005A);
      wait_cyc(4);
      check_val("port_en", 32'h0000_005A, {24'h0, cfg.port_en});
      for (int i = 0; i < 3; i++)
      begin
         wait_cyc(5);
         check_val("steady", 32'h0000_005A, {24'h0, led_status});
      end
      bus_write(`TPC_REG_PORT_EN, 32'h0000_00FF);
      // A strobe while frozen must leave the setting alone
      ce <= 1'b0;
      bus_write(`TPC_REG_PORT_EN, 32'h0000_0000);
      ce <= 1'b1;
      wait_cyc(3);
      check_val("frozen", 32'h0000_00FF, {24'h0, cfg.port_en});
      $display("t_ports done");
   endtask

   task automatic t_xover;
      bus_write(`TPC_REG_XOVER, 32'h0000_0001);
      wait_cyc(6);
      check_val("crossed", 32'h0000_007F, {24'h0, crossed});
      rd_chk(`TPC_REG_STAT, 32'h0000_0080);
      count_led(1'b0, 7, 8);
      peer_cross[7] <= 1'b1;
      wait_cyc(6);
      rd_chk(`TPC_REG_STAT, 32'h0000_0000);
      count_led(1'b0, 7, 64);
      rd_chk(`TPC_REG_OVR, 32'h0000_0012);
      peer_cross[7] <= 1'b0;
      bus_write(`TPC_REG_OVR, 32'h0000_001F);
      wait_cyc(3);
      check_val("released", 32'h0000_00FF, {24'h0, crossed});
      $display("t_xover done");
   endtask

   task automatic t_link;
      bus_write(`TPC_REG_LINK_EN, 32'h0000_00FE);
      bus_write(`TPC_REG_SQ_LOW, 32'h0000_00A5);
      wait_cyc(6);
      rd_chk(`TPC_REG_STAT, 32'h0000_0001);
      count_led(1'b0, 0, 8);
      peer_li[0] <= 1'b0;
      wait_cyc(6);
      rd_chk(`TPC_REG_STAT, 32'h0000_0000);
      count_led(1'b0, 0, 32);
      rd_chk(`TPC_REG_SQ_LOW, 32'h0000_00A5);
      check_val("sq_low", 32'h0000_00A5, {24'h0, cfg.sq_low});
      bus_write(`TPC_REG_LINK_EN, 32'h0000_00FF);
      peer_li[0] <= 1'b1;
      $display("t_link done");
   endtask

   task automatic t_jab;
      bus_write(`TPC_REG_PORT_EN, 32'h0000_00DF);
      jab  <= 8'h24;
      part <= 8'h08;
      wait_cyc(6);
      rd_chk(`TPC_REG_STAT, 32'h0000_0C00);
      count_led(1'b0, 2, 16);
      count_led(1'b0, 3, 16);
      count_led(1'b0, 5, 0);
      jab  <= 8'h00;
      part <= 8'h00;
      $display("t_jab done");
   endtask

   task automatic t_act;
      busy <= 8'h01;
      pkt  <= 8'h02;
      wait_cyc(40);
      count_led(1'b1, 0, 64);
      count_led(1'b1, 1, 32);
      count_led(1'b1, 2, 0);
      busy <= 8'h00;
      pkt  <= 8'h00;
      $display("t_act done");
   endtask

   // ---------------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------------
   initial
   begin
      clk          = 1'b0;
      rstn         = 1'b0;
      ce           = 1'b1;
      addr         = 8'h00;
      wdata        = 32'h0000_0000;
      wr           = 1'b0;
      rd           = 1'b0;
      sw_cfg       = {tpc_pkg::TPC_NET_2, 8'hFF, 8'hFF, 8'h00, 1'b0};
      peer_li      = 8'hFF;
      peer_cross   = 8'h00;
      jab          = 8'h00;
      part         = 8'h00;
      busy         = 8'h00;
      pkt          = 8'h00;
      fail_count   = 0;
      total_checks = 0;
      repeat (12) @(posedge clk);
      // Released off the edge so no assertion attempt straddles it
      @(negedge clk);
      rstn <= 1'b1;
      t_reset();
      t_net();
      t_ports();
      t_xover();
      t_link();
      t_jab();
      t_act();
      complete_run();
   end

   // Whole run needs about 820 cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      complete_run();
   end

endmodule

// file: tb/tpc_link_partner.sv
// Link partner model: transceivers on the eight twisted-pair ports
`timescale 1ns/1ps

module tpc_link_partner
(
   input  wire logic          clk,        // Port clock
   input  wire logic          rstn,       // Async reset, active low
   input  wire logic [7:0]    crossed,    // Crossover in force at hub
   input  wire logic [7:0]    hub_sq,     // Hub squelch low in force
   input  wire logic [7:0]    peer_li,    // Partner link check enabled
   input  wire logic [7:0]    peer_cross, // Partner ports crossed
   input  wire logic [7:0]    jab,        // Partner jabbers
   input  wire logic [7:0]    part,       // Port partitioned
   input  wire logic [7:0]    busy,       // Constant traffic
   input  wire logic [7:0]    pkt,        // Bursty traffic
   output tpc_pkg::tpc_line_t line        // Conditions seen at hub
);

   logic [3:0] tog;
   logic [7:0] rx_sq;

   // Transceiver follows the hub's threshold, so no frame is lost to it
   assign rx_sq = hub_sq;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tog  <= 4'h0;
         line <= '0;
      end
      else
      begin
         tog            <= tog + 4'h1;
         // Pulses only when enabled and exactly one end crossed
         line.link_ok   <= peer_li & (crossed ^ peer_cross);
         line.jabber    <= jab;
         line.partition <= part;
         line.carrier   <= (busy | (pkt & {8{tog[2]}})) & ~(rx_sq ^ hub_sq);
      end
   end

endmodule
